// *** rtl/pms_top.sv ***
// power-mode sequencer with AHB-Lite register slave
// assumes single-word AHB-Lite transfers, inputs synchronous to hclk
// Function
// - four states: active, idle, sleep, deep-sleep off, in power order
// - after programmed inactivity period step to next lower state
// - activity in any low state returns straight to active
// - deep-sleep off cuts core regulator and power amplifier supply
// - io domain stays powered and wakes the chip on user event
// - separate transmit, receive, pll, amplifier power-downs to radio
// - packet handling switches radio on and off per packet
// - low-power connection runs on slow oscillator, self-wakes
// - power actions come from register writes, packet handling, the inactivity timer or wake events
// - regulator disabled entering deep-sleep off whether or not firmware sets its disable bit
// - attention output to host when device needs host
// - extend pin lengthens crystal warm-up for clock requests
`timescale 1ns/100ps
module pms_top (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic [31:0]       hrdata,
   output logic              hreadyout,
   output logic              hresp,
   input  wire logic         user_activity,
   input  wire logic         host_attention_in,
   input  wire logic         pkt_tx_window,
   input  wire logic         pkt_rx_window,
   input  wire logic         ext_clk_req,
   input  wire logic         xtal_warmup_extend,
   output logic              device_attention_out,
   output pms_pkg::pms_rfpd_t    rf_pd,
   output pms_pkg::pms_supply_t  supply,
   output logic              lpo_select,
   output logic              xtal_ready,
   output logic              irq,
   output pms_pkg::pms_state_t   power_state
);
   typedef struct packed {
      logic                       wr_pend;
      logic [7:0]                 wr_addr;
      logic [31:0]                rdata;
      logic [4:0]                 ctrl;
      logic [31:0]                period;
      logic [31:0]                lpwake;
      logic [3:0]                 rfpd_sw;
      logic [pms_pkg::PMS_IRQ_W-1:0] irq_st;
      logic [pms_pkg::PMS_IRQ_W-1:0] mask;
      logic                       irq;
      pms_pkg::pms_state_t        state;
      logic [31:0]                idle_cnt;
      logic [31:0]                lp_cnt;
      logic [9:0]                 lpo_div;
      pms_pkg::pms_rfpd_t         rf_pd;
      pms_pkg::pms_supply_t       supply;
      logic                       attn;
      logic                       lpo_sel;
   } pms_st_t;

   pms_st_t st;
   pms_st_t next_st;
   logic    warm_ready;
   logic    xtal_q;

   // one state lower; off stays off
   function automatic pms_pkg::pms_state_t step_down(
      input pms_pkg::pms_state_t s);
      unique case (s)
         pms_pkg::PMS_ACTIVE: step_down = pms_pkg::PMS_IDLE;
         pms_pkg::PMS_IDLE:   step_down = pms_pkg::PMS_SLEEP;
         pms_pkg::PMS_SLEEP:  step_down = pms_pkg::PMS_OFF;
         pms_pkg::PMS_OFF:    step_down = pms_pkg::PMS_OFF;
      endcase
   endfunction

   // register names behind the byte offsets; the write and read phases
   // both decode through one function so the two maps cannot drift
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_CTRL,
      SEL_PERIOD,
      SEL_STATUS,
      SEL_IRQ,
      SEL_MASK,
      SEL_RFPD,
      SEL_LPWAKE
   } pms_reg_t;

   // upper address bits are ignored, so the map aliases every 256 bytes
   function automatic pms_reg_t reg_sel(input logic [7:0] a);
      unique case (a)
         pms_pkg::PMS_CTRL_OFS:   reg_sel = SEL_CTRL;
         pms_pkg::PMS_PERIOD_OFS: reg_sel = SEL_PERIOD;
         pms_pkg::PMS_STATUS_OFS: reg_sel = SEL_STATUS;
         pms_pkg::PMS_IRQ_OFS:    reg_sel = SEL_IRQ;
         pms_pkg::PMS_MASK_OFS:   reg_sel = SEL_MASK;
         pms_pkg::PMS_RFPD_OFS:   reg_sel = SEL_RFPD;
         pms_pkg::PMS_LPWAKE_OFS: reg_sel = SEL_LPWAKE;
         default:                 reg_sel = SEL_NONE; // unmapped
      endcase
   endfunction

   pms_warmup u_warm (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .clk_req   (ext_clk_req),
      .extend    (xtal_warmup_extend),
      .clk_ready (warm_ready)
   );

   always_comb begin
      logic       wake;
      logic       sw_step;
      logic       lp_tick;
      logic       lp_wake;
      logic [3:0] ev;
      logic [3:0] w1c;
      pms_pkg::pms_state_t ns;
      wake    = 1'b0;
      sw_step = 1'b0;
      lp_tick = 1'b0;
      lp_wake = 1'b0;
      ev      = 4'h0;
      w1c     = 4'h0;
      ns      = st.state;
      next_st = st;

      // ahb data phase write; registers take the word one cycle late
      next_st.wr_pend = 1'b0;
      if (st.wr_pend) begin
         unique case (reg_sel(st.wr_addr))
            SEL_CTRL:   next_st.ctrl = hwdata[4:0];
            SEL_PERIOD: next_st.period = hwdata;
            SEL_IRQ:    w1c = hwdata[3:0];
            SEL_MASK:   next_st.mask = hwdata[3:0];
            SEL_RFPD:   next_st.rfpd_sw = hwdata[3:0];
            SEL_LPWAKE: next_st.lpwake = hwdata;
            SEL_NONE, SEL_STATUS: ; // unmapped or read-only: dropped
         endcase
      end

      // ahb address phase; reads answer in the next cycle, zero wait
      if (hsel && hready && htrans[1]) begin
         next_st.wr_pend = hwrite;
         next_st.wr_addr = haddr[7:0];
         next_st.rdata   = 32'h0000_0000;
         if (!hwrite) begin
            unique case (reg_sel(haddr[7:0]))
               SEL_CTRL:   next_st.rdata = {27'h0, st.ctrl};
               SEL_PERIOD: next_st.rdata = st.period;
               SEL_STATUS:
                  next_st.rdata = {28'h0, xtal_q, 1'b0, st.state};
               SEL_IRQ:    next_st.rdata = {28'h0, st.irq_st};
               SEL_MASK:   next_st.rdata = {28'h0, st.mask};
               // live power-downs, so software sees the packet windows
               SEL_RFPD:   next_st.rdata = {28'h0, st.rf_pd};
               SEL_LPWAKE: next_st.rdata = st.lpwake;
               SEL_NONE:   next_st.rdata = 32'h0000_0000; // reads zero
            endcase
         end
      end

      // one-shot software requests clear themselves
      if (st.ctrl[pms_pkg::PMS_CTRL_FORCE_BIT]) begin
         sw_step = 1'b1;
         next_st.ctrl[pms_pkg::PMS_CTRL_FORCE_BIT] = 1'b0;
      end
      if (st.ctrl[pms_pkg::PMS_CTRL_WAKE_BIT]) begin
         wake = 1'b1;
         next_st.ctrl[pms_pkg::PMS_CTRL_WAKE_BIT] = 1'b0;
      end

      // slow-oscillator tick; self-wake counter in low-power connection
      next_st.lpo_div = st.lpo_div + 10'h001;
      if (32'(st.lpo_div) == pms_pkg::PMS_LPO_DIV - 1) begin
         next_st.lpo_div = 10'h000;
         lp_tick = 1'b1;
      end
      next_st.lpo_sel = st.ctrl[pms_pkg::PMS_CTRL_LPCONN_BIT] &&
                        st.state != pms_pkg::PMS_ACTIVE;
      if (!st.lpo_sel) begin
         next_st.lp_cnt = 32'h0000_0000;
      end else if (lp_tick) begin
         if (st.lp_cnt + 32'h1 >= st.lpwake) begin
            lp_wake = 1'b1;
            next_st.lp_cnt = 32'h0000_0000;
         end else begin
            next_st.lp_cnt = st.lp_cnt + 32'h1;
         end
      end

      // user activity (io domain watch) and host attention wake
      if (user_activity) begin
         wake = 1'b1;
      end
      if (host_attention_in) begin
         wake = 1'b1;
      end
      if (lp_wake) begin
         wake = 1'b1;
      end

      // state sequence
      if (wake) begin
         ns = pms_pkg::PMS_ACTIVE;
      end else if (sw_step ||
                   st.idle_cnt + 32'h1 >= st.period) begin
         ns = step_down(st.state);
      end
      next_st.state = ns;

      // timer restarts on activity and any state change
      if (wake || ns != st.state ||
          st.state == pms_pkg::PMS_OFF) begin
         next_st.idle_cnt = 32'h0000_0000;
      end else begin
         next_st.idle_cnt = st.idle_cnt + 32'h1;
      end

      // supplies; the io domain is never switched off
      next_st.supply.io_domain_en = 1'b1;
      next_st.supply.core_ldo_en  = !(ns == pms_pkg::PMS_OFF &&
         st.ctrl[pms_pkg::PMS_CTRL_LDO_BIT]) &&
         ns != pms_pkg::PMS_OFF;
      if (ns == pms_pkg::PMS_OFF && st.ctrl[pms_pkg::PMS_CTRL_LDO_BIT]) begin
         next_st.supply.core_ldo_en = 1'b0;
      end
      next_st.supply.pa_supply_en = ns != pms_pkg::PMS_OFF;

      // radio power-downs: software mask plus per-packet windows
      next_st.rf_pd.tx  = st.rfpd_sw[3] || !pkt_tx_window;
      next_st.rf_pd.rx  = st.rfpd_sw[2] || !pkt_rx_window;
      next_st.rf_pd.pll = st.rfpd_sw[1] ||
                          !(pkt_tx_window || pkt_rx_window);
      next_st.rf_pd.pa  = st.rfpd_sw[0] || !pkt_tx_window;
      if (ns != pms_pkg::PMS_ACTIVE) begin
         next_st.rf_pd = pms_pkg::PMS_RFPD_RST;
      end

      // attention to host follows the software need bit, one cycle late
      next_st.attn = st.ctrl[pms_pkg::PMS_CTRL_ATTN_BIT];

      // sticky events; set wins over write-one clear
      ev[pms_pkg::PMS_IRQ_STEP_BIT] = ns != st.state &&
                                      ns != pms_pkg::PMS_ACTIVE;
      ev[pms_pkg::PMS_IRQ_WAKE_BIT] = ns == pms_pkg::PMS_ACTIVE &&
                                      st.state != pms_pkg::PMS_ACTIVE;
      ev[pms_pkg::PMS_IRQ_HOST_BIT] = host_attention_in;
      ev[pms_pkg::PMS_IRQ_LPW_BIT]  = lp_wake;
      next_st.irq_st = (st.irq_st & ~w1c) | ev;
      next_st.irq    = |(next_st.irq_st & next_st.mask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st         <= '0;
         st.period  <= pms_pkg::PMS_PERIOD_RST;
         st.lpwake  <= pms_pkg::PMS_LPWAKE_RST;
         st.state   <= pms_pkg::PMS_ACTIVE;
         st.rf_pd   <= pms_pkg::PMS_RFPD_RST;
         st.supply  <= 3'b111;
         xtal_q     <= 1'b0;
      end else begin
         st     <= next_st;
         xtal_q <= warm_ready;
      end
   end

   assign hrdata               = st.rdata;
   assign hreadyout            = 1'b1;
   assign hresp                = 1'b0;
   assign device_attention_out = st.attn;
   assign rf_pd                = st.rf_pd;
   assign supply               = st.supply;
   assign lpo_select           = st.lpo_sel;
   assign xtal_ready           = xtal_q;
   assign irq                  = st.irq;
   assign power_state          = st.state;
endmodule

// *** rtl/pms_pkg.sv ***
// package for the power-mode sequencer: register map, fields, timing
// assumes a 32-bit AHB-Lite slave port, 100 MHz hclk
package pms_pkg;
   // power states, highest to lowest power
   typedef enum logic [1:0] {
      PMS_ACTIVE,
      PMS_IDLE,
      PMS_SLEEP,
      PMS_OFF
   } pms_state_t;

   // register byte offsets
   localparam logic [7:0] PMS_CTRL_OFS    = 8'h00;
   localparam logic [7:0] PMS_PERIOD_OFS  = 8'h04;
   localparam logic [7:0] PMS_STATUS_OFS  = 8'h08;
   localparam logic [7:0] PMS_IRQ_OFS     = 8'h0c;
   localparam logic [7:0] PMS_MASK_OFS    = 8'h10;
   localparam logic [7:0] PMS_RFPD_OFS    = 8'h14;
   localparam logic [7:0] PMS_LPWAKE_OFS  = 8'h18;

   // control register fields
   localparam int PMS_CTRL_ATTN_BIT   = 0; // device needs host
   localparam int PMS_CTRL_LPCONN_BIT = 1; // low-power connection mode
   localparam int PMS_CTRL_FORCE_BIT  = 2; // software step-down request
   localparam int PMS_CTRL_WAKE_BIT   = 3; // software wake request
   localparam int PMS_CTRL_LDO_BIT    = 4; // firmware regulator disable

   // interrupt status fields
   localparam int PMS_IRQ_STEP_BIT  = 0;
   localparam int PMS_IRQ_WAKE_BIT  = 1;
   localparam int PMS_IRQ_HOST_BIT  = 2;
   localparam int PMS_IRQ_LPW_BIT   = 3;
   localparam int PMS_IRQ_W         = 4;

   // reset values
   localparam logic [31:0] PMS_PERIOD_RST = 32'h000f_4240;
   localparam logic [31:0] PMS_LPWAKE_RST = 32'h0000_0100;
   localparam logic [3:0]  PMS_RFPD_RST   = 4'hf;

   // warm-up times in ns and derived cycle counts at 100 MHz
   localparam int PMS_CLK_NS         = 10;
   localparam int PMS_WARM_NS        = 1000;
   localparam int PMS_WARM_EXT_NS    = 4000;
   localparam int PMS_WARM_CYC       = (PMS_WARM_NS + PMS_CLK_NS - 1)
                                       / PMS_CLK_NS;
   localparam int PMS_WARM_EXT_CYC   = (PMS_WARM_EXT_NS + PMS_CLK_NS - 1)
                                       / PMS_CLK_NS;
   // low-power oscillator tick divider, 100 MHz / 781 ~ 128 kHz
   localparam int PMS_LPO_DIV        = 781;

   // transceiver power-down group
   typedef struct packed {
      logic tx;
      logic rx;
      logic pll;
      logic pa;
   } pms_rfpd_t;

   // supply controls
   typedef struct packed {
      logic core_ldo_en;
      logic pa_supply_en;
      logic io_domain_en;
   } pms_supply_t;
endpackage

// *** rtl/pms_warmup.sv ***
// crystal warm-up timer for external clock requests
// assumes clk_req is synchronous to hclk; extend selects longer wait
`timescale 1ns/100ps
module pms_warmup (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic clk_req,
   input  wire logic extend,
   output logic      clk_ready
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        ready;
   } pms_warm_st_t;

   pms_warm_st_t st;
   pms_warm_st_t next_st;

   // count from request; length follows the extend pin
   always_comb begin
      next_st = st;
      if (!clk_req) begin
         next_st.cnt   = 16'h0000;
         next_st.ready = 1'b0;
      end else if (!st.ready) begin
         next_st.cnt = st.cnt + 16'h0001;
         if (extend) begin
            next_st.ready = (32'(st.cnt) + 1 >=
                             32'(pms_pkg::PMS_WARM_EXT_CYC));
         end else begin
            next_st.ready = (32'(st.cnt) + 1 >=
                             32'(pms_pkg::PMS_WARM_CYC));
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign clk_ready = st.ready;
endmodule

// *** bench/pms_chk.sv ***
// port checker for the power-mode sequencer
// assumes it is bound to pms_top and sees its ports only
`timescale 1ns/100ps
module pms_chk (
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire logic                 user_activity,
   input wire logic                 host_attention_in,
   input wire logic                 ext_clk_req,
   input wire logic                 xtal_ready,
   input wire pms_pkg::pms_rfpd_t   rf_pd,
   input wire pms_pkg::pms_supply_t supply,
   input wire pms_pkg::pms_state_t  power_state
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [9:0] req_cnt;
   // run length of the clock request, saturating so it never wraps
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) req_cnt <= 10'h000;
      else if (!ext_clk_req) req_cnt <= 10'h000;
      else if (req_cnt != 10'h3ff) req_cnt <= req_cnt + 10'h001;
   end
   // a low state, then active on the next edge
   sequence low_state;
      power_state != pms_pkg::PMS_ACTIVE;
   endsequence
   sequence woken;
      ##1 power_state == pms_pkg::PMS_ACTIVE;
   endsequence
   zero_wait_a: assert property (hreadyout && !hresp)
      else $error("bus slave stalled or erred");
   act_wake_a: assert property (low_state ##0 user_activity |-> woken)
      else $error("activity did not return to active");
   host_wake_a: assert property (low_state ##0 host_attention_in |-> woken)
      else $error("host request did not return to active");
   step_next_a: assert property ($changed(power_state) &&
      power_state != pms_pkg::PMS_ACTIVE |->
      power_state == $past(power_state) + 2'h1)
      else $error("step skipped a state");
   off_core_a: assert property (supply.core_ldo_en ==
      (power_state != pms_pkg::PMS_OFF) && supply.pa_supply_en ==
      (power_state != pms_pkg::PMS_OFF))
      else $error("core or amplifier supply wrong for state");
   io_on_a: assert property (supply.io_domain_en)
      else $error("io domain lost power");
   low_rf_a: assert property (power_state inside {pms_pkg::PMS_SLEEP,
      pms_pkg::PMS_OFF} |-> rf_pd == 4'hf)
      else $error("radio powered in a sleep state");
   warm_min_a: assert property ($rose(xtal_ready) |->
      req_cnt >= pms_pkg::PMS_WARM_CYC)
      else $error("crystal ready before warm-up");
   no_req_a: assert property (!ext_clk_req [*3] |-> !xtal_ready)
      else $error("crystal ready without request");
endmodule
bind pms_top pms_chk i_chk (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .user_activity(user_activity),
   .host_attention_in(host_attention_in), .ext_clk_req(ext_clk_req),
   .xtal_ready(xtal_ready), .rf_pd(rf_pd), .supply(supply),
   .power_state(power_state));

// *** bench/pms_host_model.sv ***
// model of the host processor and the user event source
// assumes the bench asks for each event by a one-cycle request
`timescale 1ns/100ps
module pms_host_model (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic host_req,
   input  wire logic user_req,
   input  wire logic device_attention_out,
   output logic      host_attention_in,
   output logic      user_activity,
   output logic      attn_seen
);
   // events are launched one edge after the request, like a real pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         host_attention_in <= 1'b0;
         user_activity     <= 1'b0;
         attn_seen         <= 1'b0;
      end else begin
         host_attention_in <= host_req;
         user_activity     <= user_req;
         attn_seen         <= device_attention_out;
      end
   end
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the power-mode sequencer
// assumes pms_top is the only AHB-Lite slave, host model beside it
`timescale 1ns/100ps
module tb_top;
   logic                 hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
   logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata, v;
   logic [1:0]           htrans = 2'h0;
   logic                 hreadyout, hresp, user_activity, host_att, irq;
   logic                 tx_w = 1'b0, rx_w = 1'b0, creq = 1'b0;
   logic                 ext = 1'b0, attn, low_power_osc, xrdy, seen;
   logic                 host_req = 1'b0, user_req = 1'b0;
   pms_pkg::pms_rfpd_t   rf_pd;
   pms_pkg::pms_supply_t supply;
   pms_pkg::pms_state_t  st;
   int                   n_fail = 0, n_tests = 0, n;
   localparam int        lp_div = pms_pkg::PMS_LPO_DIV;
   always #5 hclk = ~hclk;
   pms_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .user_activity(user_activity),
      .host_attention_in(host_att), .pkt_tx_window(tx_w),
      .pkt_rx_window(rx_w), .ext_clk_req(creq), .xtal_warmup_extend(ext),
      .device_attention_out(attn), .rf_pd(rf_pd), .supply(supply),
      .lpo_select(low_power_osc), .xtal_ready(xrdy), .irq(irq), .power_state(st));
   pms_host_model i_host (.hclk(hclk), .hresetn(hresetn),
      .host_req(host_req), .user_req(user_req),
      .device_attention_out(attn), .host_attention_in(host_att),
      .user_activity(user_activity), .attn_seen(seen));
   // one single-word transfer; waits on hready, never on a fixed count
   task automatic ahb(input logic [7:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready_ok() !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready_ok() !== 1'b1);
      rd = hrdata;
   endtask
   function automatic logic hready_ok();
      return hreadyout;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(a, 1'b1, d, v);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      ahb(a, 1'b0, 32'h0, v);
      chk(nm, e, v);
   endtask
   // bounded wait for a state, n counts cycles taken
   task automatic wst(input pms_pkg::pms_state_t s, input int lim);
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (st !== s && n < lim);
      chk("state", {30'h0, s}, {30'h0, st});
   endtask
   // one-cycle request to the host model: host attention or user event
   task automatic pulse(input logic host);
      @(posedge hclk);
      if (host) host_req <= 1'b1;
      else user_req <= 1'b1;
      @(posedge hclk);
      host_req <= 1'b0;
      user_req <= 1'b0;
   endtask
   task automatic warm(input logic e, input int c);
      @(posedge hclk);
      ext  <= e;
      creq <= 1'b1;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (xrdy !== 1'b1 && n < 1000);
      chk("warm-up", 1, n >= c && n <= c + 3);
      @(posedge hclk);
      creq <= 1'b0;
      repeat (4) @(negedge hclk);
   endtask
   task automatic test_done();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // cycles expected well under 5000; the limit only cuts a hang
   initial begin
      #200us;
      n_fail++;
      test_done();
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rdc("period", pms_pkg::PMS_PERIOD_OFS, pms_pkg::PMS_PERIOD_RST);
      rdc("lpwake", pms_pkg::PMS_LPWAKE_OFS, pms_pkg::PMS_LPWAKE_RST);
      rdc("rfpd", pms_pkg::PMS_RFPD_OFS, 32'h0000_000f);
      rdc("status", pms_pkg::PMS_STATUS_OFS, 32'h0);
      rdc("unmapped", 8'h1c, 32'h0);
      chk("supply", 32'h7, {29'h0, supply});
      $display("test reset done");
      wr(pms_pkg::PMS_MASK_OFS, 32'h1);
      wr(pms_pkg::PMS_PERIOD_OFS, 32'd20);
      wst(pms_pkg::PMS_IDLE, 100);
      wst(pms_pkg::PMS_SLEEP, 100);
      chk("idle period", 32'd20, n);
      wst(pms_pkg::PMS_OFF, 100);
      chk("off supply", 32'h1, {29'h0, supply});
      rdc("off status", pms_pkg::PMS_STATUS_OFS, 32'h3);
      chk("irq", 1, irq);
      wr(pms_pkg::PMS_IRQ_OFS, 32'hf);
      wr(pms_pkg::PMS_PERIOD_OFS, pms_pkg::PMS_PERIOD_RST);
      chk("irq clear", 0, irq);
      pulse(1'b0);
      wst(pms_pkg::PMS_ACTIVE, 4);
      chk("on supply", 32'h7, {29'h0, supply});
      $display("test step and wake done");
      wr(pms_pkg::PMS_CTRL_OFS, 32'h4);
      wst(pms_pkg::PMS_IDLE, 4);
      pulse(1'b1);
      wst(pms_pkg::PMS_ACTIVE, 4);
      rdc("host irq", pms_pkg::PMS_IRQ_OFS, 32'h7);
      wr(pms_pkg::PMS_IRQ_OFS, 32'hf);
      wr(pms_pkg::PMS_MASK_OFS, 32'h0);
      wr(pms_pkg::PMS_CTRL_OFS, 32'h4);
      wst(pms_pkg::PMS_IDLE, 4);
      chk("masked irq", 0, irq);
      rdc("masked status", pms_pkg::PMS_IRQ_OFS, 32'h1);
      wr(pms_pkg::PMS_CTRL_OFS, 32'h8);
      wst(pms_pkg::PMS_ACTIVE, 4);
      $display("test host and irq done");
      wr(pms_pkg::PMS_CTRL_OFS, 32'h1);
      // control bit, then attention register, then the host's own flop
      repeat (3) @(negedge hclk);
      chk("attn", 1, seen);
      wr(pms_pkg::PMS_CTRL_OFS, 32'h0);
      repeat (2) @(negedge hclk);
      chk("attn off", 0, attn);
      wr(pms_pkg::PMS_RFPD_OFS, 32'h0);
      @(posedge hclk);
      tx_w <= 1'b1;
      repeat (2) @(negedge hclk);
      chk("tx on", 32'h4, {28'h0, rf_pd});
      @(posedge hclk);
      tx_w <= 1'b0;
      rx_w <= 1'b1;
      repeat (2) @(negedge hclk);
      chk("rx on", 32'h9, {28'h0, rf_pd});
      @(posedge hclk);
      rx_w <= 1'b0;
      $display("test attention and radio done");
      warm(1'b0, pms_pkg::PMS_WARM_CYC + 1);
      warm(1'b1, pms_pkg::PMS_WARM_EXT_CYC + 1);
      $display("test warm-up done");
      // low-power connection: slow oscillator, self-wake after two ticks
      wr(pms_pkg::PMS_IRQ_OFS, 32'hf);
      wr(pms_pkg::PMS_LPWAKE_OFS, 32'h2);
      wr(pms_pkg::PMS_CTRL_OFS, 32'h6);
      wst(pms_pkg::PMS_IDLE, 4);
      @(negedge hclk);
      chk("lpo select", 1, low_power_osc);
      wst(pms_pkg::PMS_ACTIVE, 1700);
      chk("self-wake", 1, n > lp_div && n <= 2 * lp_div);
      rdc("lp irq", pms_pkg::PMS_IRQ_OFS, 32'hb);
      chk("lpo off", 0, low_power_osc);
      $display("test low-power wake done");
      test_done();
   end
endmodule
